//--- rtl/pfs_map.svh
// register offsets, field positions, reset values for the port select block
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PFS_IDX_PERIPH_LOC   8'hF1
`define PFS_IDX_CONV_CFG     8'hF2
`define PFS_IDX_P1_FUNC      8'hF4
`define PFS_IDX_P2_SELPRI    8'hF5
`define PFS_IDX_P0_DIR       8'hFD
`define PFS_IDX_P1_DIR       8'hFE
`define PFS_IDX_OSC_CTRL     8'hE0
`define PFS_IDX_PIN_STATUS   8'hE1

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PFS_P2_PIN0_BIT      0
`define PFS_P2_PIN3_BIT      1
`define PFS_P2_PIN4_BIT      2
`define PFS_PRI_SER_TMR1     3
`define PFS_PRI_TMR1_TMR4    4
`define PFS_PRI_SER_TMR3     5
`define PFS_PRI_SER_SER      6
`define PFS_LOC_SER0         0
`define PFS_LOC_SER1         1
`define PFS_LOC_TMR4         4
`define PFS_LOC_TMR3         5
`define PFS_LOC_TMR1         6
`define PFS_OSC_SEL_BIT      0

// ----------------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------------
`define PFS_P2_SELPRI_MASK   8'h7F
`define PFS_PERIPH_LOC_MASK  8'h73
`define PFS_OSC_CTRL_MASK    8'h01
`define PFS_RST_BYTE         8'h00
`define PFS_RST_OSC_CTRL     8'h01
`define PFS_ADDR_HI_ZERO     22'h0

`endif

//--- rtl/pfs_pkg.sv
// types for the port select block
package pfs_pkg;

  // ----------------------------------------------------------------------
  // bus phase
  // ----------------------------------------------------------------------
  typedef enum logic {
    PFS_ST_IDLE  = 1'b0,
    PFS_ST_WDATA = 1'b1
  } pfs_phase_t;

  // ----------------------------------------------------------------------
  // whole module state
  // ----------------------------------------------------------------------
  typedef struct packed {
    pfs_phase_t  phase;
    logic [7:0]  wr_idx;
    logic [7:0]  p1_func;
    logic [7:0]  p2_selpri;
    logic [7:0]  p0_dir;
    logic [7:0]  p1_dir;
    logic [7:0]  periph_loc;
    logic [7:0]  conv_cfg;
    logic [7:0]  osc_ctrl;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  p0_oe;
    logic [7:0]  p0_analog;
    logic [7:0]  p1_periph;
    logic [7:0]  p1_oe;
    logic [4:0]  p2_periph;
    logic [4:0]  p2_analog;
    logic        p2_dd_oe;
    logic        p2_dir_override;
    logic [4:0]  loc;
    logic [3:0]  pri;
  } pfs_state_t;

endpackage : pfs_pkg

//--- rtl/pfs_port_select.sv
// port function select, priority and direction registers on an ahb-lite slave
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "pfs_map.svh"

module pfs_port_select
  import pfs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        dbg_active,
  input  wire logic        dbg_dd_drive,
  output logic      [7:0]  p0_oe,
  output logic      [7:0]  p0_analog,
  output logic      [7:0]  p1_periph,
  output logic      [7:0]  p1_oe,
  output logic      [4:0]  p2_periph,
  output logic      [4:0]  p2_analog,
  output logic             p2_dd_oe,
  output logic             p2_dir_override,
  output logic             u0_alt2,
  output logic             u1_alt2,
  output logic             t1_alt2,
  output logic             t3_alt2,
  output logic             t4_alt2,
  output logic             serial_vs_serial_priority,
  output logic             serial_vs_timer3_priority,
  output logic             timer1_vs_timer4_priority,
  output logic             serial_vs_timer1_priority
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  pfs_state_t r;
  pfs_state_t n;

  logic       addr_ok;
  logic       take;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic       osc_on;

  assign idx     = haddr[9:2];
  assign addr_ok = (haddr[31:10] == `PFS_ADDR_HI_ZERO);
  assign take    = hsel && htrans[1] && hready;
  assign wbyte   = hwdata[7:0];
  assign osc_on  = !r.osc_ctrl[`PFS_OSC_SEL_BIT];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    n           = r;
    rbyte       = `PFS_RST_BYTE;
    n.hreadyout = 1'b1;
    n.hresp     = 1'b0;

    // write data phase
    if (r.phase == PFS_ST_WDATA) begin
      case (r.wr_idx)
        `PFS_IDX_P1_FUNC:    n.p1_func    = wbyte;
        `PFS_IDX_P2_SELPRI:  n.p2_selpri  = wbyte & `PFS_P2_SELPRI_MASK;
        `PFS_IDX_P0_DIR:     n.p0_dir     = wbyte;
        `PFS_IDX_P1_DIR:     n.p1_dir     = wbyte;
        `PFS_IDX_PERIPH_LOC: n.periph_loc = wbyte & `PFS_PERIPH_LOC_MASK;
        `PFS_IDX_CONV_CFG:   n.conv_cfg   = wbyte;
        `PFS_IDX_OSC_CTRL:   n.osc_ctrl   = wbyte & `PFS_OSC_CTRL_MASK;
        default:             n.p1_func    = r.p1_func;
      endcase
    end

    // address phase
    case (r.phase)
      PFS_ST_IDLE, PFS_ST_WDATA: begin
        n.phase = PFS_ST_IDLE;
        if (take) begin
          if (hwrite && addr_ok) begin
            n.phase  = PFS_ST_WDATA;
            n.wr_idx = idx;
          end
        end
      end
      default: n.phase = PFS_ST_IDLE;
    endcase

    // read decode sees the write just applied
    if (take && !hwrite && addr_ok) begin
      case (idx)
        `PFS_IDX_P1_FUNC:    rbyte = n.p1_func;
        `PFS_IDX_P2_SELPRI:  rbyte = n.p2_selpri;
        `PFS_IDX_P0_DIR:     rbyte = n.p0_dir;
        `PFS_IDX_P1_DIR:     rbyte = n.p1_dir;
        `PFS_IDX_PERIPH_LOC: rbyte = n.periph_loc;
        `PFS_IDX_CONV_CFG:   rbyte = n.conv_cfg;
        `PFS_IDX_OSC_CTRL:   rbyte = n.osc_ctrl;
        `PFS_IDX_PIN_STATUS: rbyte = {1'b0, r.p2_dd_oe, r.p2_dir_override, r.p2_periph};
        default:             rbyte = `PFS_RST_BYTE;
      endcase
    end
    if (take) begin
      n.hrdata = {24'h000000, rbyte};
    end

    // pin steering
    n.p1_periph = r.p1_func;
    n.p1_oe     = r.p1_dir;
    n.p0_analog = r.conv_cfg;
    n.p0_oe     = r.p0_dir & ~r.conv_cfg;

    n.p2_periph    = 5'h00;
    n.p2_analog    = 5'h00;
    n.p2_periph[0] = r.p2_selpri[`PFS_P2_PIN0_BIT];
    n.p2_periph[3] = r.p2_selpri[`PFS_P2_PIN3_BIT];
    n.p2_periph[4] = r.p2_selpri[`PFS_P2_PIN4_BIT];
    if (dbg_active) begin
      n.p2_periph[2:1] = 2'b11;
    end
    n.p2_dir_override = dbg_active;
    n.p2_dd_oe        = dbg_active && dbg_dd_drive;
    if (osc_on) begin
      n.p2_periph[4:3] = 2'b00;
      n.p2_analog[4:3] = 2'b11;
    end

    // peripheral locations and port 1 priorities
    n.loc = {r.periph_loc[`PFS_LOC_TMR1], r.periph_loc[`PFS_LOC_TMR3],
             r.periph_loc[`PFS_LOC_TMR4], r.periph_loc[`PFS_LOC_SER1],
             r.periph_loc[`PFS_LOC_SER0]};
    n.pri = {r.p2_selpri[`PFS_PRI_SER_SER],
             r.p2_selpri[`PFS_PRI_SER_TMR3],
             r.p2_selpri[`PFS_PRI_TMR1_TMR4],
             r.p2_selpri[`PFS_PRI_SER_TMR1]};
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.phase           <= PFS_ST_IDLE;
      r.wr_idx          <= `PFS_RST_BYTE;
      r.p1_func         <= `PFS_RST_BYTE;
      r.p2_selpri       <= `PFS_RST_BYTE;
      r.p0_dir          <= `PFS_RST_BYTE;
      r.p1_dir          <= `PFS_RST_BYTE;
      r.periph_loc      <= `PFS_RST_BYTE;
      r.conv_cfg        <= `PFS_RST_BYTE;
      r.osc_ctrl        <= `PFS_RST_OSC_CTRL;
      r.hrdata          <= 32'h00000000;
      r.hreadyout       <= 1'b1;
      r.hresp           <= 1'b0;
      r.p0_oe           <= 8'h00;
      r.p0_analog       <= 8'h00;
      r.p1_periph       <= 8'h00;
      r.p1_oe           <= 8'h00;
      r.p2_periph       <= 5'h00;
      r.p2_analog       <= 5'h00;
      r.p2_dd_oe        <= 1'b0;
      r.p2_dir_override <= 1'b0;
      r.loc             <= 5'h00;
      r.pri             <= 4'h0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign hrdata                    = r.hrdata;
  assign hreadyout                 = r.hreadyout;
  assign hresp                     = r.hresp;
  assign p0_oe                     = r.p0_oe;
  assign p0_analog                 = r.p0_analog;
  assign p1_periph                 = r.p1_periph;
  assign p1_oe                     = r.p1_oe;
  assign p2_periph                 = r.p2_periph;
  assign p2_analog                 = r.p2_analog;
  assign p2_dd_oe                  = r.p2_dd_oe;
  assign p2_dir_override           = r.p2_dir_override;
  assign t1_alt2                   = r.loc[4];
  assign t3_alt2                   = r.loc[3];
  assign t4_alt2                   = r.loc[2];
  assign u1_alt2                   = r.loc[1];
  assign u0_alt2                   = r.loc[0];
  assign serial_vs_serial_priority = r.pri[3];
  assign serial_vs_timer3_priority = r.pri[2];
  assign timer1_vs_timer4_priority = r.pri[1];
  assign serial_vs_timer1_priority = r.pri[0];

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence wr_p1_s;
    hsel && htrans[1] && hready && hwrite && (haddr == {22'h0, `PFS_IDX_P1_FUNC, 2'b00});
  endsequence

  p1_func_write_a: assert property (wr_p1_s ##1 1'b1 |-> ##2 p1_periph == $past(hwdata[7:0], 2))
    else $error("port 1 function write not steered");
  p2_bit7_zero_a: assert property (r.p2_selpri[7] == 1'b0)
    else $error("port 2 select bit 7 not zero");
  p2_pin0_sel_a: assert property (##1 p2_periph[0] == $past(r.p2_selpri[0]))
    else $error("port 2 pin 0 select wrong");
  ser_ser_pri_a: assert property ($rose(r.p2_selpri[6]) |=> serial_vs_serial_priority)
    else $error("serial priority not applied");
  ser_tmr3_pri_a: assert property (##1 serial_vs_timer3_priority == $past(r.p2_selpri[5]))
    else $error("serial vs timer 3 priority wrong");
  tmr_tmr_pri_a: assert property (##1 timer1_vs_timer4_priority == $past(r.p2_selpri[4]))
    else $error("timer priority wrong");
  ser_tmr1_pri_a: assert property ($fell(r.p2_selpri[3]) |=> !serial_vs_timer1_priority)
    else $error("serial vs timer 1 priority wrong");
  p0_dir_oe_a: assert property (##1 p0_oe == ($past(r.p0_dir) & ~$past(r.conv_cfg)))
    else $error("port 0 output enable wrong");
  p1_dir_oe_a: assert property (##1 p1_oe == $past(r.p1_dir))
    else $error("port 1 output enable wrong");
  loc_bits_a: assert property (##1 {u1_alt2, u0_alt2} == $past(r.periph_loc[1:0]))
    else $error("serial location wrong");
  conv_analog_a: assert property (p0_analog[0] |-> !p0_oe[0])
    else $error("converter pin driven");
  dbg_own_a: assert property (dbg_active && dbg_dd_drive |=> p2_dd_oe && p2_periph[2:1] == 2'b11)
    else $error("debug pins not taken");
  osc_claim_a: assert property (!r.osc_ctrl[0] |=> p2_analog[4:3] == 2'b11 && p2_periph[4:3] == 2'b00)
    else $error("oscillator pins not claimed");

  wr_p1_c: cover property (wr_p1_s ##1 hready);
  dbg_turn_c: cover property (dbg_active && dbg_dd_drive ##1 dbg_active && !dbg_dd_drive);
  osc_on_c: cover property ($fell(r.osc_ctrl[0]));
  conv_over_c: cover property (r.p0_dir[0] && r.conv_cfg[0]);

endmodule : pfs_port_select

`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the port select block
`timescale 1ns/1ns
`default_nettype none
`include "pfs_map.svh"
module tb_top;
  localparam logic [31:0] A_P1F  = {22'h0, `PFS_IDX_P1_FUNC, 2'b00};
  localparam logic [31:0] A_P2S  = {22'h0, `PFS_IDX_P2_SELPRI, 2'b00};
  localparam logic [31:0] A_P0D  = {22'h0, `PFS_IDX_P0_DIR, 2'b00};
  localparam logic [31:0] A_P1D  = {22'h0, `PFS_IDX_P1_DIR, 2'b00};
  localparam logic [31:0] A_LOC  = {22'h0, `PFS_IDX_PERIPH_LOC, 2'b00};
  localparam logic [31:0] A_CONV = {22'h0, `PFS_IDX_CONV_CFG, 2'b00};
  localparam logic [31:0] A_OSC  = {22'h0, `PFS_IDX_OSC_CTRL, 2'b00};

  logic        hclk, hresetn, hsel, hwrite, dbg_active, dbg_dd_drive;
  logic [31:0] haddr, hwdata, hrdata, got, d, c;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, p2_dd_oe, p2_dir_override;
  logic        u0_alt2, u1_alt2, t1_alt2, t3_alt2, t4_alt2;
  logic        pri_ss, pri_st3, pri_t14, pri_st1;
  logic [7:0]  p0_oe, p0_analog, p1_periph, p1_oe;
  logic [4:0]  p2_periph, p2_analog;
  logic [31:0] exp_q[$];
  event        got_ev;
  int          bad_count, compares, cycles;

  pfs_port_select dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dbg_active(dbg_active),
    .dbg_dd_drive(dbg_dd_drive), .p0_oe(p0_oe), .p0_analog(p0_analog),
    .p1_periph(p1_periph), .p1_oe(p1_oe), .p2_periph(p2_periph), .p2_analog(p2_analog),
    .p2_dd_oe(p2_dd_oe), .p2_dir_override(p2_dir_override), .u0_alt2(u0_alt2),
    .u1_alt2(u1_alt2), .t1_alt2(t1_alt2), .t3_alt2(t3_alt2), .t4_alt2(t4_alt2),
    .serial_vs_serial_priority(pri_ss), .serial_vs_timer3_priority(pri_st3),
    .timer1_vs_timer4_priority(pri_t14), .serial_vs_timer1_priority(pri_st1)
  );

  // ----------------------------------------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic test_done;
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      test_done;
    end
  end

  // ----------------------------------------------------------------------
  // compare, bus and pin helpers
  // ----------------------------------------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  always @(got_ev) cmp(got, exp_q.pop_front());

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] v,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] r;
    bus(a, 1'b1, v, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0, r);
    got = r;
    -> got_ev;
  endtask : rd

  task automatic look;
    @(posedge hclk);
    #1;
  endtask : look

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; dbg_active = 1'b0; dbg_dd_drive = 1'b0;
    d = $urandom(32'h25DDBF22);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A_P1F, 32'h0);
    rd(A_P2S, 32'h0);
    rd(A_P0D, 32'h0);
    rd(A_P1D, 32'h0);
    rd(A_OSC, 32'h1);
    cmp({p0_oe, p1_oe, p1_periph}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 32'hFF : $urandom;
      c = (i == 0) ? 32'h0 : $urandom;
      wr(A_P1F, d);
      wr(A_P2S, d);
      wr(A_P0D, d);
      wr(A_P1D, d);
      wr(A_CONV, c);
      wr(A_LOC, d);
      look;
      cmp(p1_periph, d[7:0]);
      cmp(p1_oe, d[7:0]);
      cmp(p0_oe, d[7:0] & ~c[7:0]);
      cmp(p0_analog, c[7:0]);
      cmp(p2_periph, {d[2], d[1], 2'b00, d[0]});
      cmp(pri_ss, d[6]);
      cmp(pri_st3, d[5]);
      cmp(pri_t14, d[4]);
      cmp(pri_st1, d[3]);
      cmp({t1_alt2, t3_alt2, t4_alt2, u1_alt2, u0_alt2}, {d[6:4], d[1:0]});
      @(posedge hclk);
      rd(A_P1F, d[7:0]);
      rd(A_P2S, d[7:0] & 8'h7F);
      rd(A_P0D, d[7:0]);
      rd(A_P1D, d[7:0]);
      rd(A_LOC, d[7:0] & 8'h73);
      rd(A_CONV, c[7:0]);
      cmp(hresp, 32'h0);
    end
    dbg_active <= 1'b1;
    look;
    cmp({p2_periph[2:1], p2_dir_override, p2_dd_oe}, 32'hE);
    @(posedge hclk);
    dbg_dd_drive <= 1'b1;
    look;
    cmp(p2_dd_oe, 1'b1);
    @(posedge hclk);
    rd(32'h384, {24'h0, 3'b011, d[2], d[1], 2'b11, d[0]});
    dbg_active <= 1'b0;
    look;
    cmp({p2_dir_override, p2_dd_oe}, 32'h0);
    @(posedge hclk);
    wr(A_OSC, 32'h0);
    look;
    cmp(p2_analog[4:3], 2'b11);
    @(posedge hclk);
    wr(A_OSC, 32'h1);
    look;
    cmp(p2_analog[4:3], 2'b00);
    @(posedge hclk);
    rd(32'h3FC, 32'h0);
    wr(A_P1F | 32'h400, 32'hAA);
    rd(A_P1F, d[7:0]);
    wr(A_P1D, 32'h55);
    rd(A_P1D, 32'h55);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A_P1F, 32'h0);
    rd(A_P0D, 32'h0);
    look;
    cmp({p0_oe, p1_oe}, 32'h0);
    repeat (2) @(posedge hclk);
    test_done;
  end
endmodule : tb_top
`default_nettype wire
